// [logic/urs_consts.svh]
/*
 Holds the numeric constants of the serial port: oversampling, voting windows,
 frame lengths, line-driver mode codes and reset values.
 Assumes it is included by bare name before any module that uses it.
*/
`ifndef URS_CONSTS_SVH
`define URS_CONSTS_SVH

`define URS_SAMPLES_NORMAL 5'h10
`define URS_SAMPLES_DOUBLE 5'h08
`define URS_VOTE_FIRST_N   5'h08
`define URS_VOTE_LAST_N    5'h0A
`define URS_VOTE_FIRST_D   5'h04
`define URS_VOTE_LAST_D    5'h06
`define URS_DATA_LAST_BIT  4'h7
`define URS_ASYNC_LAST_BIT 4'h9
`define URS_SPI_LAST_EDGE  4'hF
`define URS_LDM_OFF        2'h0
`define URS_LDM_EXTERNAL   2'h1
`define URS_LDM_PIN        2'h2
`define URS_DIVISOR_RESET  16'h0000

`endif

// [logic/urs_pkg.sv]
/*
 Holds the types of the serial port: state enumerations and carrier structs.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package urs_pkg;
   typedef enum logic [4:0] {
      URS_RX_IDLE  = 5'h01,
      URS_RX_START = 5'h02,
      URS_RX_DATA  = 5'h04,
      URS_RX_STOP  = 5'h08,
      URS_RX_HOLD  = 5'h10
   } urs_rx_state_t;

   typedef enum logic [3:0] {
      URS_TX_IDLE  = 4'h1,
      URS_TX_GUARD = 4'h2,
      URS_TX_ASYNC = 4'h4,
      URS_TX_SPI   = 4'h8
   } urs_tx_state_t;

   typedef struct packed {
      logic       spi_master;
      logic       double_speed_select;
      logic       clock_phase_select;
      logic       data_order_select;
      logic [1:0] line_driver_mode;
   } urs_cfg_t;

   typedef struct packed {
      logic [7:0] data;
      logic       frame_error_flag;
   } urs_rx_frame_t;
endpackage
`default_nettype wire

// [logic/urs_sync.sv]
/*
 Holds a two-flop synchroniser for one level from outside the clock domain.
 Assumes the input may change at any time; the output idles high after reset.
*/
`default_nettype none
module urs_sync (
   input  wire logic clk_sys_in,
   input  wire logic reset_in,
   input  wire logic async_in,
   output var  logic sync_out
);
   logic meta;

   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         meta     <= 1'b1;
         sync_out <= 1'b1;
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end
endmodule
`default_nettype wire

// [logic/urs_baud.sv]
/*
 Holds the baud generator: a one-cycle sample tick every divisor plus one cycles.
 Assumes the divisor is held stable by the user while frames are in flight.
*/
`default_nettype none
`include "urs_consts.svh"
module urs_baud (
   input  wire logic        clk_sys_in,
   input  wire logic        reset_in,
   input  wire logic [15:0] divisor_in,
   output var  logic        tick_out
);
   logic [15:0] count;
   logic [15:0] next_count;
   logic        next_tick;

   always_comb begin
      next_tick  = (count == 16'h0000);
      next_count = next_tick ? divisor_in : count - 16'h0001;
   end

   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         count    <= `URS_DIVISOR_RESET;
         tick_out <= 1'b0;
      end else begin
         count    <= next_count;
         tick_out <= next_tick;
      end
   end
endmodule
`default_nettype wire

// [logic/urs_top.sv]
/*
 Holds the serial port top: oversampled asynchronous receiver, asynchronous
 and master SPI transmitter with one-word buffer, and line-driver enable.
 Assumes configuration is stable while busy and write strobes are one cycle.
*/
`default_nettype none
`include "urs_consts.svh"
module urs_top
   import urs_pkg::*;
(
   input  wire logic          clk_sys_in,
   input  wire logic          reset_in,
   input  wire urs_cfg_t      cfg_in,
   input  wire logic          rx_enable_in,
   input  wire logic          tx_enable_in,
   input  wire logic [15:0]   baud_divisor_in,
   input  wire logic [7:0]    tx_data_in,
   input  wire logic          tx_write_in,
   input  wire logic          tx_complete_clear_in,
   input  wire logic          rx_read_in,
   input  wire logic          serial_data_in,
   output var  logic          serial_data_out,
   output var  logic          serial_data_oe_out,
   output var  logic          transfer_clock_pin_out,
   output var  logic          transfer_clock_pin_oe_out,
   output var  logic          transmit_enable_out,
   output var  logic          tx_buffer_empty_out,
   output var  logic          tx_complete_out,
   output var  logic          rx_complete_out,
   output var  urs_rx_frame_t rx_frame_out
);
   logic          rx_sync;
   logic          tick;
   logic [4:0]    spb;
   logic [4:0]    vote_first;
   logic [4:0]    vote_last;
   urs_rx_state_t rx_state;
   urs_rx_state_t next_rx_state;
   logic [4:0]    rx_cnt;
   logic [4:0]    next_rx_cnt;
   logic [4:0]    rx_idx;
   logic [1:0]    rx_votes;
   logic [1:0]    next_rx_votes;
   logic [1:0]    low_count;
   logic          bit_val;
   logic [3:0]    rx_bit;
   logic [3:0]    next_rx_bit;
   logic [7:0]    rx_shift;
   logic [7:0]    next_rx_shift;
   logic          rx_prev;
   logic          next_rx_prev;
   urs_rx_frame_t next_rx_frame;
   logic          next_rx_complete;
   urs_tx_state_t tx_state;
   urs_tx_state_t next_tx_state;
   logic [7:0]    tx_buf;
   logic [7:0]    next_tx_buf;
   logic [7:0]    tx_buf_rev;
   logic          next_tx_buf_empty;
   logic [9:0]    tx_shift;
   logic [9:0]    next_tx_shift;
   logic [3:0]    tx_bit;
   logic [3:0]    next_tx_bit;
   logic [4:0]    tx_cnt;
   logic [4:0]    next_tx_cnt;
   logic [4:0]    tx_idx;
   logic [7:0]    spi_rx;
   logic [7:0]    next_spi_rx;
   logic [7:0]    spi_rx_rev;
   logic          spi_rx_done;
   logic          next_txd;
   logic          next_txd_oe;
   logic          next_sclk;
   logic          next_sclk_oe;
   logic          next_te;
   logic          next_tx_complete;
   logic          load;
   logic          rising;

   urs_sync u_rx_sync (
      .clk_sys_in (clk_sys_in),
      .reset_in   (reset_in),
      .async_in   (serial_data_in),
      .sync_out   (rx_sync)
   );

   urs_baud u_baud (
      .clk_sys_in (clk_sys_in),
      .reset_in   (reset_in),
      .divisor_in (baud_divisor_in),
      .tick_out   (tick)
   );

   // Bit reversal for msb-first SPI shifting.
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_rev
         assign tx_buf_rev[gi] = tx_buf[7 - gi];
         assign spi_rx_rev[gi] = next_spi_rx[7 - gi];
      end
   endgenerate

   // Oversampling rate and voting window follow the speed setting.
   always_comb begin
      spb        = cfg_in.double_speed_select ? `URS_SAMPLES_DOUBLE : `URS_SAMPLES_NORMAL;
      vote_first = cfg_in.double_speed_select ? `URS_VOTE_FIRST_D : `URS_VOTE_FIRST_N;
      vote_last  = cfg_in.double_speed_select ? `URS_VOTE_LAST_D : `URS_VOTE_LAST_N;
      rx_idx     = rx_cnt + 5'h01;
      tx_idx     = tx_cnt + 5'h01;
      low_count  = rx_votes + {1'b0, ~rx_sync};
      bit_val    = (low_count < 2'h2);
   end

   // Receiver next state.
   always_comb begin
      next_rx_state    = rx_state;
      next_rx_cnt      = rx_cnt;
      next_rx_votes    = rx_votes;
      next_rx_bit      = rx_bit;
      next_rx_shift    = rx_shift;
      next_rx_prev     = rx_prev;
      next_rx_frame    = rx_frame_out;
      next_rx_complete = rx_complete_out;
      if (!rx_enable_in) begin
         next_rx_state    = URS_RX_IDLE;
         next_rx_complete = 1'b0;
         next_rx_prev     = 1'b1;
      end else begin
         if (rx_read_in) begin
            next_rx_complete = 1'b0;
         end
         if (spi_rx_done) begin
            next_rx_frame    = '{data: cfg_in.data_order_select ? next_spi_rx : spi_rx_rev,
                                 frame_error_flag: 1'b0};
            next_rx_complete = 1'b1;
         end
         if (tick && !cfg_in.spi_master) begin
            next_rx_prev = rx_sync;
            next_rx_cnt  = rx_idx;
            if (rx_idx >= vote_first && rx_idx <= vote_last) begin
               next_rx_votes = low_count;
            end
            case (rx_state)
               URS_RX_IDLE: begin
                  if (rx_prev && !rx_sync) begin
                     next_rx_state = URS_RX_START;
                     next_rx_cnt   = 5'h01;
                     next_rx_votes = 2'h0;
                  end else begin
                     next_rx_cnt = 5'h00;
                  end
               end
               URS_RX_START: begin
                  if (rx_idx == vote_last && bit_val) begin
                     next_rx_state = URS_RX_IDLE;
                     next_rx_cnt   = 5'h00;
                  end else if (rx_idx == spb) begin
                     next_rx_state = URS_RX_DATA;
                     next_rx_cnt   = 5'h00;
                     next_rx_votes = 2'h0;
                     next_rx_bit   = 4'h0;
                  end
               end
               URS_RX_DATA: begin
                  if (rx_idx == vote_last) begin
                     next_rx_shift = {bit_val, rx_shift[7:1]};
                  end
                  if (rx_idx == spb) begin
                     next_rx_cnt   = 5'h00;
                     next_rx_votes = 2'h0;
                     next_rx_bit   = rx_bit + 4'h1;
                     if (rx_bit == `URS_DATA_LAST_BIT) begin
                        next_rx_state = URS_RX_STOP;
                     end
                  end
               end
               URS_RX_STOP: begin
                  if (rx_idx == vote_last) begin
                     next_rx_frame    = '{data: rx_shift, frame_error_flag: ~bit_val};
                     next_rx_complete = 1'b1;
                     next_rx_state    = cfg_in.double_speed_select ? URS_RX_HOLD
                                                                   : URS_RX_IDLE;
                  end
               end
               URS_RX_HOLD: begin
                  next_rx_state = URS_RX_IDLE;
               end
               default: begin
                  next_rx_state = URS_RX_IDLE;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         rx_state        <= URS_RX_IDLE;
         rx_cnt          <= 5'h00;
         rx_votes        <= 2'h0;
         rx_bit          <= 4'h0;
         rx_shift        <= 8'h00;
         rx_prev         <= 1'b1;
         rx_frame_out    <= '0;
         rx_complete_out <= 1'b0;
      end else begin
         rx_state        <= next_rx_state;
         rx_cnt          <= next_rx_cnt;
         rx_votes        <= next_rx_votes;
         rx_bit          <= next_rx_bit;
         rx_shift        <= next_rx_shift;
         rx_prev         <= next_rx_prev;
         rx_frame_out    <= next_rx_frame;
         rx_complete_out <= next_rx_complete;
      end
   end

   // Transmitter and SPI master next state.
   always_comb begin
      next_tx_state     = tx_state;
      next_tx_buf       = tx_buf;
      next_tx_buf_empty = tx_buffer_empty_out;
      next_tx_shift     = tx_shift;
      next_tx_bit       = tx_bit;
      next_tx_cnt       = tx_cnt;
      next_spi_rx       = spi_rx;
      next_sclk         = transfer_clock_pin_out;
      next_tx_complete  = tx_complete_out;
      spi_rx_done       = 1'b0;
      load              = 1'b0;
      rising            = ~transfer_clock_pin_out;
      if (tx_complete_clear_in) begin
         next_tx_complete = 1'b0;
      end
      if (tx_write_in && tx_buffer_empty_out && tx_enable_in) begin
         next_tx_buf       = tx_data_in;
         next_tx_buf_empty = 1'b0;
      end
      if (tick) begin
         case (tx_state)
            URS_TX_IDLE: begin
               load = ~tx_buffer_empty_out;
               if (load && cfg_in.line_driver_mode != `URS_LDM_OFF && !cfg_in.spi_master) begin
                  next_tx_state = URS_TX_GUARD;
               end
            end
            URS_TX_GUARD: begin
               next_tx_cnt = tx_idx;
               if (tx_idx == spb) begin
                  next_tx_state = URS_TX_ASYNC;
                  next_tx_cnt   = 5'h00;
               end
            end
            URS_TX_ASYNC: begin
               next_tx_cnt = tx_idx;
               if (tx_idx == spb) begin
                  next_tx_cnt   = 5'h00;
                  next_tx_shift = {1'b1, tx_shift[9:1]};
                  next_tx_bit   = tx_bit + 4'h1;
                  if (tx_bit == `URS_ASYNC_LAST_BIT) begin
                     load = ~tx_buffer_empty_out;
                     if (!load) begin
                        next_tx_state    = URS_TX_IDLE;
                        next_tx_complete = 1'b1;
                     end
                  end
               end
            end
            URS_TX_SPI: begin
               next_sclk   = ~transfer_clock_pin_out;
               next_tx_bit = tx_bit + 4'h1;
               if (rising ^ cfg_in.clock_phase_select) begin
                  next_spi_rx = {rx_sync, spi_rx[7:1]};
               end else if (tx_bit != 4'h0 && tx_bit != `URS_SPI_LAST_EDGE) begin
                  next_tx_shift = {1'b1, tx_shift[9:1]};
               end
               if (tx_bit == `URS_SPI_LAST_EDGE) begin
                  spi_rx_done = rx_enable_in;
                  load        = ~tx_buffer_empty_out;
                  if (!load) begin
                     next_tx_state    = URS_TX_IDLE;
                     next_tx_complete = 1'b1;
                  end
               end
            end
            default: begin
               next_tx_state = URS_TX_IDLE;
            end
         endcase
      end
      if (load) begin
         next_tx_buf_empty = 1'b1;
         next_tx_cnt       = 5'h00;
         next_tx_bit       = 4'h0;
         next_sclk         = 1'b0;
         if (cfg_in.spi_master) begin
            next_tx_state = URS_TX_SPI;
            next_tx_shift = {2'h3, cfg_in.data_order_select ? tx_buf : tx_buf_rev};
         end else begin
            next_tx_shift = {1'b1, tx_buf, 1'b0};
            if (tx_state == URS_TX_IDLE && next_tx_state != URS_TX_GUARD) begin
               next_tx_state = URS_TX_ASYNC;
            end
         end
      end
      next_txd     = (next_tx_state == URS_TX_ASYNC || next_tx_state == URS_TX_SPI)
                     ? next_tx_shift[0] : 1'b1;
      next_te      = (cfg_in.line_driver_mode != `URS_LDM_OFF) && !cfg_in.spi_master
                     && (next_tx_state == URS_TX_GUARD || next_tx_state == URS_TX_ASYNC);
      next_txd_oe  = (cfg_in.line_driver_mode == `URS_LDM_PIN && !cfg_in.spi_master)
                     ? next_te
                     : (tx_enable_in || next_tx_state != URS_TX_IDLE || !next_tx_buf_empty);
      next_sclk_oe = cfg_in.spi_master
                     && (tx_enable_in || next_tx_state != URS_TX_IDLE);
   end

   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         tx_state                  <= URS_TX_IDLE;
         tx_buf                    <= 8'h00;
         tx_buffer_empty_out       <= 1'b1;
         tx_shift                  <= 10'h3FF;
         tx_bit                    <= 4'h0;
         tx_cnt                    <= 5'h00;
         spi_rx                    <= 8'h00;
         serial_data_out           <= 1'b1;
         serial_data_oe_out        <= 1'b0;
         transfer_clock_pin_out    <= 1'b0;
         transfer_clock_pin_oe_out <= 1'b0;
         transmit_enable_out       <= 1'b0;
         tx_complete_out           <= 1'b0;
      end else begin
         tx_state                  <= next_tx_state;
         tx_buf                    <= next_tx_buf;
         tx_buffer_empty_out       <= next_tx_buf_empty;
         tx_shift                  <= next_tx_shift;
         tx_bit                    <= next_tx_bit;
         tx_cnt                    <= next_tx_cnt;
         spi_rx                    <= next_spi_rx;
         serial_data_out           <= next_txd;
         serial_data_oe_out        <= next_txd_oe;
         transfer_clock_pin_out    <= next_sclk;
         transfer_clock_pin_oe_out <= next_sclk_oe;
         transmit_enable_out       <= next_te;
         tx_complete_out           <= next_tx_complete;
      end
   end

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (reset_in);

   sequence s_stop_vote;
      tick && rx_enable_in && !cfg_in.spi_master && rx_state == URS_RX_STOP
      && rx_idx == vote_last;
   endsequence

   sequence s_start_vote;
      tick && rx_enable_in && !cfg_in.spi_master && rx_state == URS_RX_START
      && rx_idx == vote_last;
   endsequence

   AST_SYNC_TWO_FLOPS: assert property (rx_sync == $past(serial_data_in, 2))
      else $error("serial input not delayed by two flops");
   AST_START_REJECT: assert property (s_start_vote ##0 bit_val |=> rx_state == URS_RX_IDLE)
      else $error("noisy start bit not rejected");
   AST_START_ACCEPT: assert property (s_start_vote ##0 !bit_val |=> rx_state == URS_RX_START)
      else $error("valid start bit dropped");
   AST_STOP_STORES: assert property (s_stop_vote |=> rx_complete_out
      && rx_frame_out.frame_error_flag == $past(~bit_val))
      else $error("stop bit vote not stored with frame");
   AST_STOP_ENDS: assert property (s_stop_vote |=> rx_state != URS_RX_STOP)
      else $error("receiver kept sampling after first stop bit");
   AST_SPI_NO_FRAME_ERROR_FLAG: assert property (cfg_in.spi_master && $rose(rx_complete_out)
      |-> !rx_frame_out.frame_error_flag)
      else $error("frame error seen in SPI mode");
   AST_NO_SELF_START: assert property (tx_state == URS_TX_IDLE && tx_buffer_empty_out
      |=> tx_state == URS_TX_IDLE)
      else $error("transfer began without a write");
   AST_LOAD_READY: assert property (tick && tx_state == URS_TX_IDLE && !tx_buffer_empty_out
      |=> tx_state != URS_TX_IDLE && tx_buffer_empty_out)
      else $error("buffered data not moved to shift register");
   AST_TE_GUARD: assert property ($rose(transmit_enable_out)
      |-> serial_data_out && tx_state == URS_TX_GUARD)
      else $error("transmit enable rose without guard period");
   AST_TE_FRAME: assert property (tx_state == URS_TX_ASYNC
      && cfg_in.line_driver_mode != `URS_LDM_OFF |-> transmit_enable_out)
      else $error("transmit enable dropped inside frame");
   AST_SCLK_ON_TICK: assert property ($changed(transfer_clock_pin_out)
      |-> $past(tick) && $past(tx_state) inside {URS_TX_SPI, URS_TX_IDLE})
      else $error("transfer clock moved off a baud tick");
endmodule
`default_nettype wire

// [dv/urs_remote.sv]
/* Remote node: asynchronous sender and SPI slave.
   Assumes the bench gives a link clock and the device pins. */
`default_nettype none
module urs_remote (
   input  wire logic lk_in,
   input  wire logic spi_in,
   input  wire logic sclk_in,
   input  wire logic mosi_in,
   output var  logic sdi_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic       line = 1'b1;
   logic       miso = 1'b1;
   logic       ph = 1'b0;
   logic [7:0] rep = 8'h00;
   logic [7:0] got = 8'h00;
   int         p = 0;
   assign sdi_out = spi_in ? miso : line;
   task automatic send(input logic [7:0] d, input logic stop, input int n);
      for (int i = 0; i < 10; i++) begin
         @(posedge lk_in);
         line = i == 0 ? 1'b0 : (i == 9 ? stop : d[i - 1]);
         repeat (n - 1) @(posedge lk_in);
      end
      if (!stop) begin
         @(posedge lk_in);
         line = 1'b1;
      end
   endtask
   task automatic glitch();
      @(posedge lk_in);
      line = 1'b0;
      @(posedge lk_in);
      line = 1'b1;
   endtask
   task automatic start(input logic [7:0] r, input logic c);
      rep = r;
      ph = c;
      p = c ? -1 : 0;
      miso = c ? ~miso : r[7];
   endtask
   always @(sclk_in) begin
      if (sclk_in ^ ph) begin
         got = {got[6:0], mosi_in};
      end else begin
         p = p + 1;
         miso = (p >= 0 && p < 8) ? rep[7 - p] : ~miso;
      end
   end
endmodule
`default_nettype wire

// [dv/urs_top_test.sv]
/* Bench for the serial port: receive, noise, frame error, double speed,
   line-driver send and master SPI. Assumes the remote model on the pins. */
`default_nettype none
module urs_top_test;
   import urs_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic          clk = 1'b0;
   logic          rst = 1'b1;
   logic          lk = 1'b0;
   urs_cfg_t      cfg = '0;
   logic [15:0]   div = 16'h0001;
   logic [7:0]    txd = 8'h00;
   logic          wr_s = 1'b0;
   logic          clr = 1'b0;
   logic          rd_s = 1'b0;
   logic          rx_en = 1'b1;
   logic          tx_en = 1'b1;
   logic          sdi, sdo, sck, te, txc, rxc, tbe, soe, coe;
   urs_rx_frame_t fr;
   int            n_fail = 0;
   int            n_tests = 0;
   initial forever #20 clk = ~clk;
   initial begin
      #7;
      forever #160 lk = ~lk;
   end
   urs_top DUT (
      .clk_sys_in(clk), .reset_in(rst), .cfg_in(cfg), .rx_enable_in(rx_en),
      .tx_enable_in(tx_en), .baud_divisor_in(div), .tx_data_in(txd), .tx_write_in(wr_s),
      .tx_complete_clear_in(clr), .rx_read_in(rd_s), .serial_data_in(sdi),
      .serial_data_out(sdo), .serial_data_oe_out(soe), .transfer_clock_pin_out(sck),
      .transfer_clock_pin_oe_out(coe), .transmit_enable_out(te), .tx_buffer_empty_out(tbe),
      .tx_complete_out(txc), .rx_complete_out(rxc), .rx_frame_out(fr));
   urs_remote remote (.lk_in(lk), .spi_in(cfg.spi_master), .sclk_in(sck),
      .mosi_in(sdo), .sdi_out(sdi));
   task automatic summarize();
      $display("checks %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input string s, input logic [8:0] e, input logic [8:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", s, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wait_for(input int k);
      for (int i = 0; i <= 5000; i++) begin
         if ((k == 0 ? rxc : (k == 1 ? txc : te)) === 1'b1) begin
            return;
         end
         if (i == 5000) begin
            chk("wait", 9'h001, 9'h000);
            summarize();
         end
         cyc(1);
      end
   endtask
   task automatic rd(input logic [7:0] d, input logic fe);
      wait_for(0);
      chk("rx_frame", {d, fe}, fr);
      rd_s = 1'b1;
      cyc(1);
      rd_s = 1'b0;
   endtask
   task automatic wr(input logic [7:0] d);
      txd = d;
      wr_s = 1'b1;
      cyc(1);
      wr_s = 1'b0;
   endtask
   task automatic tx_frame(input logic [7:0] d);
      logic [10:0] f;
      f = {1'b1, d, 2'b01};
      wait_for(2);
      chk("tbe", 9'h001, {8'h00, tbe});
      for (int i = 0; i < 11; i++) begin
         cyc(i == 0 ? 16 : 32);
         chk("sdo", {8'h00, f[i]}, {8'h00, sdo});
         chk("te", 9'h001, {8'h00, te});
         chk("soe", 9'h001, {8'h00, soe});
      end
      cyc(24);
      chk("te", 9'h000, {8'h00, te});
      chk("txc", 9'h001, {8'h00, txc});
      chk("soe", {8'h00, cfg.line_driver_mode != 2'h2}, {8'h00, soe});
      chk("coe", 9'h000, {8'h00, coe});
      clr = 1'b1;
      cyc(1);
      clr = 1'b0;
   endtask
   initial begin
      cyc(3);
      rst = 1'b0;
      fork
         begin
            remote.send(8'hA6, 1'b1, 4);
            remote.send(8'h5B, 1'b1, 4);
         end
      join_none
      rd(8'hA6, 1'b0);
      rd(8'h5B, 1'b0);
      remote.glitch();
      cyc(400);
      chk("rxc", 9'h000, {8'h00, rxc});
      fork
         remote.send(8'h3C, 1'b0, 4);
      join_none
      rd(8'h3C, 1'b1);
      cyc(100);
      cfg.double_speed_select = 1'b1;
      fork
         remote.send(8'hC3, 1'b1, 2);
      join_none
      rd(8'hC3, 1'b0);
      $display("receive tests done");
      cyc(100);
      cfg.double_speed_select = 1'b0;
      fork
         remote.send(8'h55, 1'b1, 4);
      join_none
      cyc(100);
      rx_en = 1'b0;
      cyc(300);
      rx_en = 1'b1;
      tx_en = 1'b0;
      wr(8'hFF);
      chk("tbe", 9'h001, {8'h00, tbe});
      chk("soe", 9'h000, {8'h00, soe});
      tx_en = 1'b1;
      cyc(50);
      chk("rxc", 9'h000, {8'h00, rxc});
      $display("enable tests done");
      for (int m = 1; m < 3; m++) begin
         cfg.line_driver_mode = m[1:0];
         wr(8'h96);
         chk("tbe", 9'h000, {8'h00, tbe});
         tx_frame(8'h96);
      end
      $display("line driver tests done");
      div = 16'h0003;
      for (int k = 0; k < 4; k++) begin
         cfg = {2'h2, k[0], k[1], 2'h0};
         remote.start(8'h2D, k[0]);
         cyc(2);
         wr(8'hB1);
         chk("tbe", 9'h000, {8'h00, tbe});
         wait_for(1);
         chk("coe", 9'h001, {8'h00, coe});
         chk("sck", 9'h000, {8'h00, sck});
         rd(k[1] ? 8'hB4 : 8'h2D, 1'b0);
         chk("mosi", {1'b0, k[1] ? 8'h8D : 8'hB1}, {1'b0, remote.got});
         clr = 1'b1;
         cyc(1);
         clr = 1'b0;
      end
      $display("spi tests done");
      summarize();
   end
endmodule
`default_nettype wire
